// *** gpbc_ports.sv ***
// Port B and port C general purpose I/O with an APB register slave.
// Assumes pins are asynchronous; prescaler taps and sleep from same clock.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "gpbc_consts.svh"
module gpbc_ports
    import gpbc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [16:0] presc_tap_in,
    input wire logic sleep_in,
    input wire logic [3:0] pb_pin_in,
    output logic [3:0] pb_pin_out,
    output logic [3:0] pb_pin_oe_out,
    output logic [3:0] pb_pull_up_out,
    output logic [3:0] pb_pull_down_out,
    input wire logic [3:0] pc_pin_in,
    output logic [3:0] pc_pin_out,
    output logic [3:0] pc_pin_oe_out,
    output logic [3:0] pc_pull_up_out,
    output logic [3:0] pc_pull_down_out,
    output logic input_reset_wakes_sleep_out
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [3:0] b_data_r, b_data_nxt;
    logic [3:0] b_dir_r, b_dir_nxt;
    logic [3:0] b_fsel_r, b_fsel_nxt;
    logic [3:0] b_nopd_r, b_nopd_nxt;
    logic [3:0] b_od_r, b_od_nxt;
    logic [3:0] c_data_r, c_data_nxt;
    logic c_dir_r, c_dir_nxt;
    logic [3:0] c_opt_r, c_opt_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [3:0] pb_sync, pc_sync;
    logic wr_en, rd_en;

    gpbc_sync #(.WIDTH(4)) u_sync_b (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .d_in(pb_pin_in),
        .q_out(pb_sync)
    );
    gpbc_sync #(.WIDTH(4)) u_sync_c (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .d_in(pc_pin_in),
        .q_out(pc_sync)
    );

    // ----------------------------------------------------------------
    // APB slave: one wait state, answer while pready is high
    // ----------------------------------------------------------------
    assign wr_en = psel_in && penable_in && !pready_r && pwrite_in;
    assign rd_en = psel_in && penable_in && !pready_r && !pwrite_in;

    always_comb begin
        b_data_nxt = b_data_r;
        b_dir_nxt = b_dir_r;
        b_fsel_nxt = b_fsel_r;
        b_nopd_nxt = b_nopd_r;
        b_od_nxt = b_od_r;
        c_data_nxt = c_data_r;
        c_dir_nxt = c_dir_r;
        c_opt_nxt = c_opt_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (wr_en || rd_en) begin
            pready_nxt = 1'b1;
            prdata_nxt = `GPBC_RST_WORD;
            unique case (paddr_in)
                `GPBC_OFF_B_DATA: begin
                    if (wr_en) b_data_nxt = pwdata_in[3:0];
                    prdata_nxt[3:0] = pb_sync; // RULE_01
                end
                `GPBC_OFF_B_DIR: begin
                    if (wr_en) b_dir_nxt = pwdata_in[3:0]; // RULE_02
                    prdata_nxt[3:0] = b_dir_r;
                end
                `GPBC_OFF_B_FSEL: begin
                    if (wr_en) b_fsel_nxt = pwdata_in[3:0]; // RULE_03
                    prdata_nxt[3:0] = b_fsel_r;
                end
                `GPBC_OFF_B_NOPD: begin
                    if (wr_en) b_nopd_nxt = pwdata_in[3:0]; // RULE_05
                    prdata_nxt[3:0] = b_nopd_r;
                end
                `GPBC_OFF_B_OD: begin
                    if (wr_en) b_od_nxt = pwdata_in[3:0]; // RULE_06
                    prdata_nxt[3:0] = b_od_r;
                end
                `GPBC_OFF_C_DATA: begin
                    if (wr_en) c_data_nxt = pwdata_in[3:0]; // RULE_08
                    prdata_nxt[3:0] = pc_sync; // RULE_09
                end
                `GPBC_OFF_C_CTRL: begin
                    // Upper bits always read zero
                    if (wr_en) c_dir_nxt = pwdata_in[`GPBC_CCTRL_DIR_BIT]; // RULE_07
                    prdata_nxt[`GPBC_CCTRL_DIR_BIT] = c_dir_r;
                end
                `GPBC_OFF_C_OPT: begin
                    if (wr_en) c_opt_nxt = pwdata_in[3:0]; // RULE_12
                    prdata_nxt[3:0] = c_opt_r;
                end
                `GPBC_OFF_STATUS: begin
                    prdata_nxt[3:0] = pb_pin_oe_out;
                    prdata_nxt[7:4] = pc_pin_oe_out;
                    prdata_nxt[8] = sleep_in;
                end
                default: begin
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
    end

    // Any reset clears every control bit, port C back to input
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            b_data_r <= `GPBC_RST_NIB;
            b_dir_r <= `GPBC_RST_NIB; // RULE_02
            b_fsel_r <= `GPBC_RST_NIB; // RULE_03 RULE_04
            b_nopd_r <= `GPBC_RST_NIB;
            b_od_r <= `GPBC_RST_NIB;
            c_data_r <= `GPBC_RST_NIB;
            c_dir_r <= 1'b0; // RULE_10
            c_opt_r <= `GPBC_RST_NIB;
            prdata_r <= `GPBC_RST_WORD;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            b_data_r <= b_data_nxt;
            b_dir_r <= b_dir_nxt;
            b_fsel_r <= b_fsel_nxt;
            b_nopd_r <= b_nopd_nxt;
            b_od_r <= b_od_nxt;
            c_data_r <= c_data_nxt;
            c_dir_r <= c_dir_nxt;
            c_opt_r <= c_opt_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pad control
    // ----------------------------------------------------------------
    logic [3:0] b_src;
    gpbc_pad_type pb_pad, pc_pad;

    // Frequency taps override the latch value on their pins
    always_comb begin
        b_src = b_data_r;
        if (b_fsel_r[`GPBC_FSEL_TAP11_BIT]) b_src[2] = presc_tap_in[`GPBC_TAP11]; // RULE_03
        if (b_fsel_r[`GPBC_FSEL_TAP16_BIT]) b_src[1] = presc_tap_in[`GPBC_TAP16]; // RULE_03
        if (b_fsel_r[`GPBC_FSEL_TAP12_BIT]) b_src[0] = presc_tap_in[`GPBC_TAP12]; // RULE_03
    end

    gpbc_pad_ctrl u_pad_b (
        .data_in(b_src),
        .dir_in(b_dir_r),
        .od_in(b_od_r),
        .nopd_in(b_nopd_r),
        .hiz_in(1'b0),
        .pad_out(pb_pad)
    );
    gpbc_pad_ctrl u_pad_c (
        .data_in(c_data_r),
        .dir_in({4{c_dir_r}}), // RULE_07
        .od_in({4{c_opt_r[`GPBC_COPT_OD_BIT]}}), // RULE_12
        // Port C output mode has no pull-down, only the open drain pull-up; port B keeps its pull-down
        .nopd_in({4{c_opt_r[`GPBC_COPT_NOPD_BIT] | c_dir_r}}),
        .hiz_in(sleep_in), // RULE_11
        .pad_out(pc_pad)
    );

    // Pin outputs registered: one cycle of latency from a write
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            pb_pin_out <= `GPBC_RST_NIB;
            pb_pin_oe_out <= `GPBC_RST_NIB;
            pb_pull_up_out <= `GPBC_RST_NIB;
            pb_pull_down_out <= `GPBC_RST_NIB;
            pc_pin_out <= `GPBC_RST_NIB;
            pc_pin_oe_out <= `GPBC_RST_NIB;
            pc_pull_up_out <= `GPBC_RST_NIB;
            pc_pull_down_out <= `GPBC_RST_NIB;
            input_reset_wakes_sleep_out <= 1'b0;
        end else begin
            pb_pin_out <= pb_pad.out; // RULE_13
            pb_pin_oe_out <= pb_pad.oe;
            pb_pull_up_out <= pb_pad.pull_up;
            pb_pull_down_out <= pb_pad.pull_down;
            pc_pin_out <= pc_pad.out; // RULE_08
            pc_pin_oe_out <= pc_pad.oe; // RULE_11
            pc_pull_up_out <= pc_pad.pull_up;
            pc_pull_down_out <= pc_pad.pull_down;
            input_reset_wakes_sleep_out <= b_fsel_r[`GPBC_FSEL_WAKE_BIT]; // RULE_04
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
endmodule : gpbc_ports
`default_nettype wire

// *** gpbc_consts.svh ***
// Constants of the port B and port C block: offsets, fields, reset values.
// Assumes inclusion by the gpbc_ports module; definitions only.
//
// Operation
// RULE_01: Port B data read returns pin levels
// RULE_02: Port B per-pin direction, zero is input
// RULE_03: Frequency select routes taps 11,16,12 out
// RULE_04: Select bit zero lets input reset wake
// RULE_05: Per-pin pull-down disable, zero keeps pull-down
// RULE_06: Per-pin open drain select, zero is CMOS
// RULE_07: One bit sets port C direction
// RULE_08: Port C latch drives pins in output
// RULE_09: Port C read returns sampled pin levels
// RULE_10: Any reset clears port C control
// RULE_11: Port C high impedance during sleep
// RULE_12: One bit picks port C open drain
// RULE_13: Port B output follows data latch
// RULE_14: Pull-up only for open drain, high or input
// RULE_15: Never pull-up and pull-down together
`ifndef GPBC_CONSTS_SVH
`define GPBC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GPBC_OFF_B_DATA 12'h000
`define GPBC_OFF_B_DIR 12'h004
`define GPBC_OFF_B_FSEL 12'h008
`define GPBC_OFF_B_NOPD 12'h00C
`define GPBC_OFF_B_OD 12'h010
`define GPBC_OFF_C_DATA 12'h014
`define GPBC_OFF_C_CTRL 12'h018
`define GPBC_OFF_C_OPT 12'h01C
`define GPBC_OFF_STATUS 12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GPBC_FSEL_WAKE_BIT 0
`define GPBC_FSEL_TAP12_BIT 1
`define GPBC_FSEL_TAP16_BIT 2
`define GPBC_FSEL_TAP11_BIT 3
`define GPBC_CCTRL_DIR_BIT 0
`define GPBC_COPT_OD_BIT 2
`define GPBC_COPT_NOPD_BIT 3
`define GPBC_TAP11 11
`define GPBC_TAP12 12
`define GPBC_TAP16 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPBC_RST_NIB 4'h0
`define GPBC_RST_WORD 32'h0000_0000

`endif

// *** gpbc_pkg.sv ***
// Types shared by the port B and port C block.
// Assumes gpbc_consts.svh is in the include path.
package gpbc_pkg;
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
        logic [3:0] pull_up;
        logic [3:0] pull_down;
    } gpbc_pad_type;
endpackage : gpbc_pkg

// *** gpbc_sync.sv ***
// Two-flop synchroniser for the four pin levels of one port.
// Assumes pins are asynchronous to sys_clk_in.
`timescale 1ns/100ps
`default_nettype none
module gpbc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end
    assign q_out = q_r;
endmodule : gpbc_sync
`default_nettype wire

// *** gpbc_pad_ctrl.sv ***
// Per-pin drive and pull computation for one four-bit port.
// Assumes config bits are on the same clock; output is combinational.
`timescale 1ns/100ps
`default_nettype none
module gpbc_pad_ctrl
    import gpbc_pkg::*;
(
    input wire logic [3:0] data_in,
    input wire logic [3:0] dir_in,
    input wire logic [3:0] od_in,
    input wire logic [3:0] nopd_in,
    input wire logic hiz_in,
    output wire gpbc_pad_type pad_out
);
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_pin
            logic drv;
            // Open drain drives only low; CMOS follows the latch
            assign drv = dir_in[i] && !hiz_in && !(od_in[i] && data_in[i]); // RULE_06 RULE_13
            assign pad_out.out[i] = data_in[i]; // RULE_13
            assign pad_out.oe[i] = drv; // RULE_02
            // Pull-up and pull-down are exclusive through the od term
            assign pad_out.pull_up[i] = !hiz_in && od_in[i]
                && (!dir_in[i] || data_in[i]); // RULE_14 RULE_15
            assign pad_out.pull_down[i] = !hiz_in && !od_in[i]
                && !nopd_in[i]; // RULE_05 RULE_14 RULE_15
        end
    endgenerate
endmodule : gpbc_pad_ctrl
`default_nettype wire

// *** gpbc_check_assertions.sv ***
// Checker for gpbc_ports: APB timing, pull exclusion, sleep and reset.
// Assumes the master holds each request until pready is seen high.
`timescale 1ns/100ps
`default_nettype none
module gpbc_check (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sleep_in,
    input wire logic [3:0] pb_pin_oe_out,
    input wire logic [3:0] pb_pull_up_out,
    input wire logic [3:0] pb_pull_down_out,
    input wire logic [3:0] pc_pin_oe_out,
    input wire logic [3:0] pc_pull_up_out,
    input wire logic [3:0] pc_pull_down_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_taken;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_answer;
        pready_out ##1 !pready_out;
    endsequence
    a_one_wait: assert property (s_taken |=> s_answer) else $error("pready timing");
    a_err_unmapped: assert property ((s_taken and (paddr_in > 12'h020)) |=> pslverr_out)
        else $error("no error on unmapped");
    a_ok_mapped: assert property ((s_taken and (paddr_in <= 12'h020 && paddr_in[1:0] == 2'h0))
        |=> !pslverr_out) else $error("error on mapped");
    a_upper_zero: assert property (pready_out |-> prdata_out[31:9] == 23'h0)
        else $error("upper read bits set");
    a_pull_excl_b: assert property ((pb_pull_up_out & pb_pull_down_out) == 4'h0)
        else $error("both pulls on port b");
    a_pull_excl_c: assert property ((pc_pull_up_out & pc_pull_down_out) == 4'h0)
        else $error("both pulls on port c");
    a_od_release: assert property ((pb_pull_up_out & pb_pin_oe_out) == 4'h0)
        else $error("pull-up on driven pin");
    a_sleep_hiz: assert property (sleep_in [*3] |-> pc_pin_oe_out == 4'h0
        && (pc_pull_up_out | pc_pull_down_out) == 4'h0) else $error("port c driven in sleep");
    a_reset_input: assert property ($past(!rst_b_in) |-> (pb_pin_oe_out | pc_pin_oe_out)
        == 4'h0) else $error("driver on after reset");
endmodule : gpbc_check
bind gpbc_ports gpbc_check gpbc_check_i (.sys_clk_in, .rst_b_in, .psel_in, .penable_in,
    .paddr_in, .prdata_out, .pready_out, .pslverr_out, .sleep_in, .pb_pin_oe_out,
    .pb_pull_up_out, .pb_pull_down_out, .pc_pin_oe_out, .pc_pull_up_out, .pc_pull_down_out);
`default_nettype wire

// *** gpbc_board.sv ***
// Board model: resolves the eight port pins from drivers, pulls and the bench.
// Assumes an outside driver never fights an enabled pin driver.
`timescale 1ns/100ps
`default_nettype none
module gpbc_board (
    input wire logic sys_clk_in,
    input wire logic [7:0] out_in,
    input wire logic [7:0] oe_in,
    input wire logic [7:0] pu_in,
    input wire logic [7:0] pd_in,
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_in,
    output logic [7:0] pin_out
);
    logic [7:0] float_r = 8'h00;
    // A floating line flips each cycle so a stale level never passes for a read
    always @(posedge sys_clk_in) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe_in[i]) pin_out[i] = out_in[i];
            else if (ext_en_in[i]) pin_out[i] = ext_in[i];
            else if (pu_in[i]) pin_out[i] = 1'b1;
            else if (pd_in[i]) pin_out[i] = 1'b0;
            else pin_out[i] = float_r[i];
        end
    end
endmodule : gpbc_board
`default_nettype wire

// *** gpbc_ports_test.sv ***
// Self-checking bench for gpbc_ports over APB with a board model.
// Assumes a one-wait-state slave; pins read back through two sync flops.
`timescale 1ns/100ps
`default_nettype none
module gpbc_ports_test;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic pwrite_in = 1'b0, sleep_in = 1'b0, pslverr_out, pready_out, input_reset_wakes_sleep_out;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000, prdata_out;
    logic [16:0] presc_tap_in = 17'h0_0000;
    logic [3:0] pb_pin_out, pb_pin_oe_out, pb_pull_up_out, pb_pull_down_out;
    logic [3:0] pc_pin_out, pc_pin_oe_out, pc_pull_up_out, pc_pull_down_out, q;
    logic [7:0] ext_en = 8'h00, ext = 8'h00;
    wire logic [7:0] pins;
    logic e;
    int n_fail = 0, comparisons = 0, cyc = 0;
    logic [11:0] cfg [6] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h018, 12'h01C};
    gpbc_ports gpbc_ports_i (.sys_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .presc_tap_in, .sleep_in,
        .pb_pin_in(pins[3:0]), .pb_pin_out, .pb_pin_oe_out, .pb_pull_up_out, .pb_pull_down_out,
        .pc_pin_in(pins[7:4]), .pc_pin_out, .pc_pin_oe_out, .pc_pull_up_out, .pc_pull_down_out,
        .input_reset_wakes_sleep_out);
    gpbc_board gpbc_board_i (.sys_clk_in, .out_in({pc_pin_out, pb_pin_out}),
        .oe_in({pc_pin_oe_out, pb_pin_oe_out}), .pu_in({pc_pull_up_out, pb_pull_up_out}),
        .pd_in({pc_pull_down_out, pb_pull_down_out}), .ext_en_in(ext_en), .ext_in(ext),
        .pin_out(pins));
    initial forever #2.5 sys_clk_in = ~sys_clk_in;
    // ----
    // Tasks
    // ----
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // Hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [3:0] d);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= {28'h000_0000, d};
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (pready_out !== 1'b1);
        q = prdata_out[3:0];
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic w(input int k);
        repeat (k) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask : w
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        foreach (cfg[i]) begin
            apb(1'b0, cfg[i], 4'h0);
            chk(q, 4'h0);
        end
        chk(pb_pull_down_out, 4'hF);
        chk({3'h0, input_reset_wakes_sleep_out}, 4'h0);
        $display("test reset done");
        apb(1'b1, 12'h004, 4'hF);
        apb(1'b1, 12'h000, 4'hA);
        w(2);
        chk(pb_pin_out, 4'hA);
        chk(pb_pin_oe_out, 4'hF);
        chk(pb_pull_down_out, 4'hF);
        apb(1'b0, 12'h020, 4'h0);
        chk(q, 4'hF);
        apb(1'b0, 12'h000, 4'h0);
        chk(q, 4'hA);
        ext_en <= 8'h0C;
        ext <= 8'h04;
        apb(1'b1, 12'h004, 4'h3);
        w(2);
        chk(pb_pin_oe_out, 4'h3);
        apb(1'b0, 12'h000, 4'h0);
        chk(q, 4'h6);
        ext_en <= 8'h00;
        $display("test port b io done");
        apb(1'b1, 12'h004, 4'h0);
        apb(1'b1, 12'h00C, 4'h5);
        w(2);
        chk(pb_pull_down_out, 4'hA);
        apb(1'b1, 12'h010, 4'hF);
        apb(1'b1, 12'h000, 4'h5);
        apb(1'b1, 12'h004, 4'hF);
        w(2);
        chk(pb_pin_oe_out, 4'hA);
        chk(pb_pin_out & pb_pin_oe_out, 4'h0);
        chk(pb_pull_up_out, 4'h5);
        chk(pb_pull_down_out, 4'h0);
        apb(1'b0, 12'h000, 4'h0);
        chk(q, 4'h5);
        apb(1'b1, 12'h004, 4'h0);
        w(2);
        chk(pb_pull_up_out, 4'hF);
        $display("test port b pulls done");
        apb(1'b1, 12'h010, 4'h0);
        apb(1'b1, 12'h004, 4'hF);
        apb(1'b1, 12'h000, 4'h8);
        apb(1'b1, 12'h008, 4'hE);
        presc_tap_in <= 17'h1_0800;
        w(2);
        chk(pb_pin_out, 4'hE);
        @(posedge sys_clk_in);
        presc_tap_in <= 17'h0_1000;
        w(2);
        chk(pb_pin_out, 4'h9);
        apb(1'b1, 12'h008, 4'h1);
        w(2);
        chk(pb_pin_out, 4'h8);
        chk({3'h0, input_reset_wakes_sleep_out}, 4'h1);
        $display("test taps done");
        apb(1'b1, 12'h018, 4'hF);
        apb(1'b1, 12'h014, 4'h9);
        w(2);
        chk(pc_pin_out, 4'h9);
        chk(pc_pin_oe_out, 4'hF);
        chk(pc_pull_down_out, 4'h0);
        apb(1'b0, 12'h018, 4'h0);
        chk(q, 4'h1);
        apb(1'b1, 12'h01C, 4'h4);
        w(2);
        chk(pc_pin_oe_out, 4'h6);
        chk(pc_pull_up_out, 4'h9);
        apb(1'b0, 12'h014, 4'h0);
        chk(q, 4'h9);
        ext_en <= 8'hF0;
        ext <= 8'h60;
        apb(1'b1, 12'h018, 4'h0);
        w(2);
        chk(pc_pin_oe_out, 4'h0);
        apb(1'b0, 12'h014, 4'h0);
        chk(q, 4'h6);
        ext_en <= 8'h00;
        apb(1'b1, 12'h01C, 4'h0);
        w(2);
        chk(pc_pull_down_out, 4'hF);
        apb(1'b1, 12'h01C, 4'h8);
        w(2);
        chk(pc_pull_down_out, 4'h0);
        apb(1'b1, 12'h018, 4'h1);
        @(posedge sys_clk_in);
        sleep_in <= 1'b1;
        w(4);
        chk(pc_pin_oe_out, 4'h0);
        chk(pc_pull_up_out | pc_pull_down_out, 4'h0);
        @(posedge sys_clk_in);
        sleep_in <= 1'b0;
        rst_b_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        apb(1'b0, 12'h018, 4'h0);
        chk(q, 4'h0);
        chk(pc_pin_oe_out, 4'h0);
        $display("test port c done");
        apb(1'b1, 12'h024, 4'hF);
        chk({3'h0, e}, 4'h1);
        apb(1'b0, 12'h024, 4'h0);
        chk(q, 4'h0);
        chk({3'h0, e}, 4'h1);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule : gpbc_ports_test
`default_nettype wire
